// ==== acm_pkg.sv ====
// Shared constants for the converter sequencing control block
`default_nettype none
package acm_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_SEQ_ENABLE = 12'h000;
  localparam logic [11:0] OFF_PRIORITY = 12'h020;
  localparam logic [11:0] OFF_START = 12'h028;
  localparam logic [11:0] OFF_AVG = 12'h030;
  localparam logic [11:0] OFF_INPUT_SEL_SLOT_FIRST = 12'h040;
  localparam logic [11:0] OFF_SEQ0_LAST = 12'h048;
  localparam logic [11:0] OFF_STATUS = 12'h04c;
  // Field layout and reset values
  localparam int NUM_SEQ = 4;
  localparam int NUM_SLOT = 8;
  localparam int FIELD_STRIDE = 4;
  localparam int SEL_W = 2;
  localparam int AVG_W = 3;
  localparam int CONV_W = 10;
  localparam int MAX_EXP = 6;
  localparam int SUM_W = CONV_W + MAX_EXP;
  localparam logic [31:0] PRIORITY_MASK = 32'h00003333;
  localparam logic [31:0] PRIORITY_RESET = 32'h00003210;
  localparam logic [31:0] MUX_MASK = 32'h33333333;
  localparam logic [31:0] MUX_RESET = 32'h00000000;
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam logic [2:0] AVG_RESET = 3'h0;
  localparam logic [2:0] SEQ0_LAST_RESET = 3'h0;
  localparam logic [SEL_W-1:0] OTHER_SEQ_SEL = 2'h0;
  // Status register bit positions
  localparam int ST_PEND_LSB = 0;
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_SEQ_LSB = 8;
  // Sequencing states
  typedef enum logic [1:0] {
    ST_IDLE, ST_START, ST_WAIT, ST_SETTLE
  } acm_state_e;
endpackage : acm_pkg
`default_nettype wire

// ==== acm_arbiter.sv ====
// Picks the pending sequencer with the most urgent priority encoding
`default_nettype none
module acm_arbiter (
  input wire logic [3:0] pending,
  input wire logic [31:0] priority_reg,
  output logic grant_valid,
  output logic [1:0] grant_idx
);
  // Encoding 0 is most urgent; ties go to the lower sequencer number
  function automatic logic [1:0] prio_of(input logic [31:0] r,
                                        input int n);
    prio_of = r[n*acm_pkg::FIELD_STRIDE +: acm_pkg::SEL_W];
  endfunction : prio_of

  always_comb begin
    logic [2:0] best;
    best = 3'h4;
    grant_valid = 1'b0;
    grant_idx = 2'h0;
    for (int n = 0; n < acm_pkg::NUM_SEQ; n++) begin
      if (pending[n] && ({1'b0, prio_of(priority_reg, n)} < best)) begin
        best = {1'b0, prio_of(priority_reg, n)}; // see [R12]
        grant_valid = 1'b1;
        grant_idx = n[1:0];
      end
    end
  end
endmodule : acm_arbiter
`default_nettype wire

// ==== acm_averager.sv ====
// Accumulates 2^n conversions and emits their mean
`default_nettype none
module acm_averager (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sample_valid,
  input wire logic [acm_pkg::CONV_W-1:0] sample,
  input wire logic [2:0] exponent,
  output logic avg_valid_q,
  output logic [acm_pkg::CONV_W-1:0] avg_data_q
);
  logic [acm_pkg::MAX_EXP:0] count_q;
  logic [acm_pkg::SUM_W-1:0] sum_q;
  logic [acm_pkg::SUM_W-1:0] sum_d;
  logic [2:0] exp_eff;

  // Exponent 7 is undefined; treat it as 6 to keep sum width bounded
  assign exp_eff = (exponent > 3'(acm_pkg::MAX_EXP)) ?
                   3'(acm_pkg::MAX_EXP) : exponent;
  assign sum_d = sum_q + acm_pkg::SUM_W'(sample);

  // Window ends after 2^exp samples; exp 0 passes each sample through
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_q <= '0;
      sum_q <= '0;
      avg_valid_q <= 1'b0;
      avg_data_q <= '0;
    end else begin
      avg_valid_q <= 1'b0;
      if (sample_valid) begin
        if (count_q == ((acm_pkg::MAX_EXP+1)'(1) << exp_eff) - 1'b1) begin
          avg_data_q <= acm_pkg::CONV_W'(sum_d >> exp_eff); // see [R3] [R5]
          avg_valid_q <= 1'b1; // see [R4]
          count_q <= '0;
          sum_q <= '0;
        end else begin
          count_q <= count_q + 1'b1;
          sum_q <= sum_d;
        end
      end
    end
  end
endmodule : acm_averager
`default_nettype wire

// ==== acm_seq_ctrl.sv ====
// Register file, trigger and sequencing control for the converter
// Overview of operation
// [R1] Writing one to start bit n triggers sequencer n if it is enabled.
// [R2] Start register is write-only; reads return zero, bits 31:4 unused.
// [R3] Each stored result is the mean of 2^exponent consecutive conversions.
// [R4] Exponent zero passes every conversion straight through.
// [R5] Exponent six averages sixty-four conversions into one result.
// [R6] Software must keep the exponent within zero to six.
// [R7] Exponent is a read/write field at bits 2:0, reset zero.
// [R8] Sequencer zero input select holds eight slots, each used for its sample.
// [R9] A slot value k selects analog input k.
// [R10] Slot fields two bits wide, four apart, eighth at 29:28, reset zero.
// [R11] Reserved bits read as zero here; software leaves them unchanged.
// [R12] Simultaneous triggers run in order of their priority encodings.
// [R13] First three slots sit at bits 1:0, 5:4 and 9:8, reset zero.
// [R14] Writing zero to a start bit leaves that sequencer alone.
//
// Local design decision: strobed register access.
`default_nettype none
module acm_seq_ctrl (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  output logic conv_start_q,
  output logic [acm_pkg::SEL_W-1:0] conv_input_sel_q,
  input wire logic conv_done,
  input wire logic [acm_pkg::CONV_W-1:0] conv_data,
  output logic result_valid_q,
  output logic [acm_pkg::CONV_W-1:0] result_data_q,
  output logic [1:0] result_seq_q
);
  logic [3:0] enable_q;
  logic [31:0] priority_q;
  logic [2:0] avg_exp_q;
  logic [31:0] input_sel_slot_first_q;
  logic [2:0] seq0_last_q;
  logic [3:0] pending_q;
  logic [3:0] pending_set;
  logic [3:0] pending_clr;
  acm_pkg::acm_state_e state_q;
  logic [1:0] cur_seq_q;
  logic [2:0] slot_q;
  logic grant_valid;
  logic [1:0] grant_idx;
  logic avg_valid;
  logic [acm_pkg::CONV_W-1:0] avg_data;
  logic sample_valid;

  // Write decode shared by every writable register
  function automatic logic wr_hit(input logic wr, input logic [11:0] a,
                                  input logic [11:0] off);
    wr_hit = wr && (a == off);
  endfunction : wr_hit

  // Slot k of the select register
  function automatic logic [1:0] slot_sel(input logic [31:0] r,
                                         input logic [2:0] k);
    slot_sel = r[k*acm_pkg::FIELD_STRIDE +: acm_pkg::SEL_W];
  endfunction : slot_sel

  // Configuration registers written by software
  always_ff @(posedge core_clk) begin
    if (srst) begin
      enable_q <= acm_pkg::ENABLE_RESET;
      priority_q <= acm_pkg::PRIORITY_RESET;
      avg_exp_q <= acm_pkg::AVG_RESET; // see [R7]
      input_sel_slot_first_q <= acm_pkg::MUX_RESET; // see [R10] [R13]
      seq0_last_q <= acm_pkg::SEQ0_LAST_RESET;
    end else begin
      if (wr_hit(reg_wr, reg_addr, acm_pkg::OFF_SEQ_ENABLE))
        enable_q <= reg_wdata[3:0];
      if (wr_hit(reg_wr, reg_addr, acm_pkg::OFF_PRIORITY))
        priority_q <= reg_wdata & acm_pkg::PRIORITY_MASK;
      if (wr_hit(reg_wr, reg_addr, acm_pkg::OFF_AVG))
        avg_exp_q <= reg_wdata[2:0]; // see [R7]
      if (wr_hit(reg_wr, reg_addr, acm_pkg::OFF_INPUT_SEL_SLOT_FIRST))
        input_sel_slot_first_q <= reg_wdata & acm_pkg::MUX_MASK; // see [R10] [R11]
      if (wr_hit(reg_wr, reg_addr, acm_pkg::OFF_SEQ0_LAST))
        seq0_last_q <= reg_wdata[2:0];
    end
  end

  // Trigger requests: only ones of enabled sequencers count, zeros ignored
  assign pending_set = wr_hit(reg_wr, reg_addr, acm_pkg::OFF_START) ?
                       (reg_wdata[3:0] & enable_q) : 4'h0; // see [R1] [R14]
  assign pending_clr = (state_q == acm_pkg::ST_IDLE && grant_valid) ?
                       (4'h1 << grant_idx) : 4'h0;

  // A trigger landing on its own dispatch cycle is kept: set wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pending_q <= 4'h0;
    end else begin
      pending_q <= (pending_q & ~pending_clr) | pending_set; // see [R1]
    end
  end

  acm_arbiter u_arbiter (
    .pending(pending_q),
    .priority_reg(priority_q),
    .grant_valid(grant_valid),
    .grant_idx(grant_idx)
  );

  assign sample_valid = (state_q == acm_pkg::ST_WAIT) && conv_done;

  acm_averager u_averager (
    .core_clk(core_clk),
    .srst(srst),
    .sample_valid(sample_valid),
    .sample(conv_data),
    .exponent(avg_exp_q),
    .avg_valid_q(avg_valid),
    .avg_data_q(avg_data)
  );

  // Sequencing: start, wait for the core, settle one cycle for the mean
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= acm_pkg::ST_IDLE;
      cur_seq_q <= 2'h0;
      slot_q <= 3'h0;
    end else begin
      case (state_q)
        acm_pkg::ST_IDLE: begin
          if (grant_valid) begin
            cur_seq_q <= grant_idx; // see [R12]
            slot_q <= 3'h0;
            state_q <= acm_pkg::ST_START;
          end
        end
        acm_pkg::ST_START: state_q <= acm_pkg::ST_WAIT;
        acm_pkg::ST_WAIT: begin
          if (conv_done)
            state_q <= acm_pkg::ST_SETTLE;
        end
        acm_pkg::ST_SETTLE: begin
          // Averaging window open: convert the same slot again
          if (!avg_valid)
            state_q <= acm_pkg::ST_START; // see [R3]
          else if (cur_seq_q == 2'h0 && slot_q != seq0_last_q) begin
            slot_q <= slot_q + 1'b1; // see [R8]
            state_q <= acm_pkg::ST_START;
          end else
            state_q <= acm_pkg::ST_IDLE;
        end
        default: state_q <= acm_pkg::ST_IDLE;
      endcase
    end
  end

  // Converter command: one-cycle start, select held through conversion
  always_ff @(posedge core_clk) begin
    if (srst) begin
      conv_start_q <= 1'b0;
      conv_input_sel_q <= '0;
    end else begin
      conv_start_q <= (state_q == acm_pkg::ST_START);
      if (state_q == acm_pkg::ST_START)
        conv_input_sel_q <= (cur_seq_q == 2'h0) ?
                            slot_sel(input_sel_slot_first_q, slot_q) : // see [R8] [R9]
                            acm_pkg::OTHER_SEQ_SEL;
    end
  end

  // Result strobe toward the sequencer FIFOs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      result_valid_q <= 1'b0;
      result_data_q <= '0;
      result_seq_q <= 2'h0;
    end else begin
      result_valid_q <= (state_q == acm_pkg::ST_SETTLE) && avg_valid;
      if ((state_q == acm_pkg::ST_SETTLE) && avg_valid) begin
        result_data_q <= avg_data; // see [R3]
        result_seq_q <= cur_seq_q;
      end
    end
  end

  // Read port; reserved bits and unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata_q <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        acm_pkg::OFF_SEQ_ENABLE: reg_rdata_q <= {28'h0, enable_q};
        acm_pkg::OFF_PRIORITY: reg_rdata_q <= priority_q;
        acm_pkg::OFF_START: reg_rdata_q <= 32'h0; // see [R2]
        acm_pkg::OFF_AVG: reg_rdata_q <= {29'h0, avg_exp_q}; // see [R11]
        acm_pkg::OFF_INPUT_SEL_SLOT_FIRST: reg_rdata_q <= input_sel_slot_first_q;
        acm_pkg::OFF_SEQ0_LAST: reg_rdata_q <= {29'h0, seq0_last_q};
        acm_pkg::OFF_STATUS: begin
          reg_rdata_q <= 32'h0;
          reg_rdata_q[acm_pkg::ST_PEND_LSB +: 4] <= pending_q;
          reg_rdata_q[acm_pkg::ST_BUSY_BIT] <= state_q != acm_pkg::ST_IDLE;
          reg_rdata_q[acm_pkg::ST_SEQ_LSB +: 2] <= cur_seq_q;
        end
        default: reg_rdata_q <= 32'h0;
      endcase
    end else begin
      reg_rdata_q <= 32'h0;
    end
  end

  // Enabled trigger write marks the sequencer pending next cycle
  property p_trigger_enabled;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == acm_pkg::OFF_START && reg_wdata[0] && enable_q[0])
    |=> pending_q[0];
  endproperty
  a_trigger_enabled: assert property (p_trigger_enabled) // see [R1]
    else $error("enabled trigger lost");

  property p_trigger_disabled;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == acm_pkg::OFF_START && !enable_q[1] && !pending_q[1])
    |=> !pending_q[1];
  endproperty
  a_trigger_disabled: assert property (p_trigger_disabled) // see [R1]
    else $error("disabled sequencer became pending");

  property p_start_reads_zero;
    @(posedge core_clk) disable iff (srst)
    (reg_rd && reg_addr == acm_pkg::OFF_START) |=> reg_rdata_q == 32'h0;
  endproperty
  a_start_reads_zero: assert property (p_start_reads_zero) // see [R2]
    else $error("start register read not zero");

  property p_zero_write;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == acm_pkg::OFF_START && reg_wdata[3:0] == 4'h0
     && state_q != acm_pkg::ST_IDLE) |=> pending_q == $past(pending_q);
  endproperty
  a_zero_write: assert property (p_zero_write) // see [R14]
    else $error("zero write changed pending");

  property p_pass_through;
    @(posedge core_clk) disable iff (srst)
    (sample_valid && avg_exp_q == 3'h0) |-> ##2
    (result_valid_q && result_data_q == $past(conv_data, 2));
  endproperty
  a_pass_through: assert property (p_pass_through) // see [R4]
    else $error("exponent zero did not pass sample through");

  property p_avg_readback;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == acm_pkg::OFF_AVG) ##1
    (reg_rd && reg_addr == acm_pkg::OFF_AVG) |=>
    reg_rdata_q == {29'h0, $past(reg_wdata[2:0], 2)};
  endproperty
  a_avg_readback: assert property (p_avg_readback) // see [R7] [R11]
    else $error("averaging field readback wrong");

  property p_sel_follows_slot;
    @(posedge core_clk) disable iff (srst)
    (state_q == acm_pkg::ST_START && cur_seq_q == 2'h0) |=>
    conv_start_q && conv_input_sel_q == $past(slot_sel(input_sel_slot_first_q, slot_q));
  endproperty
  a_sel_follows_slot: assert property (p_sel_follows_slot) // see [R8] [R9]
    else $error("input select does not follow slot field");

  property p_grant_priority;
    @(posedge core_clk) disable iff (srst)
    (state_q == acm_pkg::ST_IDLE && pending_q[0] && pending_q[1] &&
     priority_q[5:4] < priority_q[1:0]) |=> cur_seq_q != 2'h0 &&
    ($past(pending_q[3:2]) != 2'h0 || cur_seq_q == 2'h1);
  endproperty
  a_grant_priority: assert property (p_grant_priority) // see [R12]
    else $error("lower priority sequencer served first");

  property p_mux_reserved;
    @(posedge core_clk) disable iff (srst)
    (reg_rd && reg_addr == acm_pkg::OFF_INPUT_SEL_SLOT_FIRST) |=>
    (reg_rdata_q & ~acm_pkg::MUX_MASK) == 32'h0;
  endproperty
  a_mux_reserved: assert property (p_mux_reserved) // see [R10] [R13]
    else $error("select register reserved bits set");

  // Exponent and select fields come out of reset cleared
  property p_reset_fields;
    @(posedge core_clk)
    srst |=> avg_exp_q == acm_pkg::AVG_RESET &&
    input_sel_slot_first_q == acm_pkg::MUX_RESET;
  endproperty
  a_reset_fields: assert property (p_reset_fields) // see [R7] [R10] [R13]
    else $error("configuration field not cleared by reset");

  // A zero in a start bit never raises that sequencer's request
  property p_zero_bit_ignored;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == acm_pkg::OFF_START && !reg_wdata[2] &&
     !pending_q[2]) |=> !pending_q[2];
  endproperty
  a_zero_bit_ignored: assert property (p_zero_bit_ignored) // see [R14]
    else $error("zero start bit raised a request");

  // Select fields keep exactly what software wrote, reserved bits dropped
  property p_mux_write;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == acm_pkg::OFF_INPUT_SEL_SLOT_FIRST) |=>
    input_sel_slot_first_q == ($past(reg_wdata) & acm_pkg::MUX_MASK);
  endproperty
  a_mux_write: assert property (p_mux_write) // see [R8] [R10]
    else $error("select register lost a written field");
endmodule : acm_seq_ctrl
`default_nettype wire

// ==== acm_core_model.sv ====
// Behavioural converter core answering start pulses with input levels
`default_nettype none
module acm_core_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic conv_start,
  input wire logic [acm_pkg::SEL_W-1:0] conv_sel,
  input wire logic [7:0] lat,
  output logic conv_done,
  output logic [acm_pkg::CONV_W-1:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q;
  logic busy_q;
  logic [acm_pkg::SEL_W-1:0] sel_q;
  // One conversion outstanding; data toggles away from the done cycle
  // so a design sampling at the wrong moment sees garbage, not a match
  always_ff @(posedge core_clk) begin
    conv_done <= 1'b0;
    if (srst) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      sel_q <= 2'h0;
      conv_data <= 10'h155;
    end else if (conv_start) begin
      busy_q <= 1'b1;
      cnt_q <= lat;
      sel_q <= conv_sel;
      conv_data <= ~conv_data;
    end else if (busy_q && cnt_q == 8'h00) begin
      busy_q <= 1'b0;
      conv_done <= 1'b1;
      conv_data <= 10'h100 + {4'h0, sel_q, 4'h0};
    end else begin
      cnt_q <= cnt_q - 8'h01;
      conv_data <= ~conv_data;
    end
  end
endmodule : acm_core_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the converter sequencing control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } acm_row_s;
  localparam logic [31:0] MUXV = 32'h30002031;
  logic core_clk, srst, reg_wr, reg_rd, conv_done;
  logic conv_start_q, result_valid_q;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, rd;
  logic [1:0] conv_input_sel_q, result_seq_q, s;
  logic [9:0] conv_data, result_data_q;
  logic [7:0] lat;
  logic [1:0] sel_q[$];
  logic [11:0] res_q[$];
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // Plain register cases: address, written word, expected read back
  acm_row_s rows [7] = '{
    '{12'h030, 32'h00000005, 32'h00000005},
    '{12'h030, 32'h00000006, 32'h00000006},
    '{12'h040, 32'h33333333, 32'h33333333},
    '{12'h040, 32'h12301230, 32'h12301230},
    '{12'h028, 32'h0000000f, 32'h00000000},
    '{12'h07c, 32'hffffffff, 32'h00000000},
    '{12'h030, 32'h00000000, 32'h00000000}};

  acm_seq_ctrl acm_seq_ctrl_i (.core_clk(core_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .conv_start_q(conv_start_q), .conv_input_sel_q(conv_input_sel_q),
    .conv_done(conv_done), .conv_data(conv_data),
    .result_valid_q(result_valid_q), .result_data_q(result_data_q),
    .result_seq_q(result_seq_q));
  acm_core_model acm_core_model_i (.core_clk(core_clk), .srst(srst),
    .conv_start(conv_start_q), .conv_sel(conv_input_sel_q), .lat(lat),
    .conv_done(conv_done), .conv_data(conv_data));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Log dispatches and results; a hang is cut short here
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (conv_start_q) sel_q.push_back(conv_input_sel_q);
    if (result_valid_q) res_q.push_back({result_seq_q, result_data_q});
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe; taken at its end
  // Starts at once so a read can follow a write with no gap
  task automatic rdr(input logic [11:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    rd = reg_rdata_q;
  endtask : rdr

  task automatic wait_res(input int n);
    int k;
    k = 0;
    while (res_q.size() < n && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    repeat (10) @(posedge core_clk);
  endtask : wait_res

  task automatic stop_test();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    lat = 8'h00;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rdr(12'h030);
    check(rd, 32'h0);
    rdr(12'h040);
    check(rd, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdr(rows[i].a);
      check(rd, rows[i].e);
    end
    // Nothing enabled yet, so the start write above must stay silent
    repeat (10) @(posedge core_clk);
    check(32'(sel_q.size()), 32'h0);
    // Eight-slot run on sequencer zero with a slow core
    wr(12'h040, MUXV);
    wr(12'h000, 32'h1);
    wr(12'h048, 32'h7);
    lat <= 8'h05;
    wr(12'h028, 32'he);
    wr(12'h028, 32'h1);
    wait_res(8);
    check(32'(res_q.size()), 32'h8);
    check(32'(sel_q.size()), 32'h8);
    for (int k = 0; k < 8; k++) begin
      s = MUXV[4*k +: 2];
      check({30'h0, sel_q.pop_front()}, {30'h0, s});
      check({20'h0, res_q.pop_front()},
        {20'h0, 2'h0, 10'h100 + {4'h0, s, 4'h0}});
    end
    // Averaging on sequencer one, exponents one and six (windows of two and sixty-four)
    lat <= 8'h00;
    wr(12'h000, 32'h2);
    for (int e = 1; e < 7; e += 5) begin
      wr(12'h030, 32'(e));
      wr(12'h028, 32'h2);
      // Status two cycles after the trigger: busy on sequencer one
      @(posedge core_clk);
      rdr(12'h04c);
      check(rd, 32'h00000110);
      // A zero write in mid-run must neither restart nor cancel
      wr(12'h028, 32'h0);
      wait_res(1);
      check(32'(sel_q.size()), 32'h1 << e);
      check(32'(res_q.size()), 32'h1);
      check({20'h0, res_q.pop_front()}, {20'h0, 2'h1, 10'h100});
      sel_q.delete();
    end
    // All four at once; reversed priorities set the serving order
    wr(12'h030, 32'h0);
    wr(12'h048, 32'h0);
    wr(12'h000, 32'hf);
    wr(12'h020, 32'h00000123);
    wr(12'h028, 32'hf);
    wait_res(4);
    check(32'(res_q.size()), 32'h4);
    for (int i = 0; i < 4; i++) begin
      check({30'h0, res_q[i][11:10]}, 32'(3 - i));
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
